// ### design/smp_pkg.sv
// constants, register map and field layout of the serial module pin control
// assumes a 32-bit apb slave on a single 20 mhz clock
package smp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // printed offsets are not all multiples of four: index = offset
    localparam logic [15:0] SMP_IDX_DATA = 16'hfc15;
    localparam logic [15:0] SMP_IDX_ASSIGN = 16'hfc16;
    localparam logic [15:0] SMP_IDX_DIR = 16'hfc17;
    localparam logic [15:0] SMP_IDX_CTRL = 16'hfc18;
    localparam int SMP_ADDR_W = 18;
    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SMP_ASSIGN_MASK = 8'h7b;
    localparam logic [7:0] SMP_ASSIGN_RST = 8'h00;
    localparam logic [7:0] SMP_DIR_RST = 8'h00;
    localparam logic [7:0] SMP_DATA_RST = 8'h00;
    localparam logic [2:0] SMP_CTRL_RST = 3'h0;
    localparam int SMP_PIN_MISO = 0;
    localparam int SMP_PIN_MOSI = 1;
    localparam int SMP_PIN_SCK = 2;
    localparam int SMP_PIN_CS0 = 3;
    localparam int SMP_PIN_TXD = 7;
    localparam int SMP_CTRL_ENA = 0;
    localparam int SMP_CTRL_MSTR = 1;
    localparam int SMP_CTRL_TE = 2;
    localparam int SMP_STAT_FAULT = 8;
    localparam logic [31:0] SMP_BYTE_SHIFT = 32'd8;
    // apb access phase states
    typedef enum logic [0:0] {
        SMP_IDLE = 1'b0,
        SMP_ACK = 1'b1
    } smp_bus_t;
    // byte address of a register index
    function automatic logic [SMP_ADDR_W-1:0] smp_addr(
        input logic [15:0] idx);
        smp_addr = {idx, 2'b00};
    endfunction
endpackage

// ### design/smp_apb.sv
// apb slave holding the pin control registers
// assumes the apb master keeps the request stable until pready
`timescale 1ns/1ps
module smp_apb (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smp_pkg::SMP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // register contents and status
    output logic [7:0] data_q,
    output logic [7:0] assign_q,
    output logic [7:0] dir_q,
    output logic [2:0] ctrl_q,
    input wire logic [7:0] pin_level,
    input wire logic fault_flag
);
    import smp_pkg::*;
    smp_bus_t st_q;
    logic wr_go;
    logic [31:0] rd_d;
    logic hit;
    // ------------------------------------------------------------
    // access phase: one wait state, answer on the second edge
    // ------------------------------------------------------------
    assign wr_go = psel && penable && pwrite && (st_q == SMP_IDLE);
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= SMP_IDLE;
            pready <= 1'b0;
        end else if (psel && penable && st_q == SMP_IDLE) begin
            st_q <= SMP_ACK;
            pready <= 1'b1;
        end else begin
            st_q <= SMP_IDLE;
            pready <= 1'b0;
        end
    end
    // writes; unimplemented bits are dropped
    always_ff @(posedge mclk) begin
        if (reset) begin
            data_q <= SMP_DATA_RST;
            assign_q <= SMP_ASSIGN_RST;
            dir_q <= SMP_DIR_RST;
            ctrl_q <= SMP_CTRL_RST;
        end else if (wr_go) begin
            if (paddr == smp_addr(SMP_IDX_DATA)) begin
                data_q <= pwdata[7:0];
            end else if (paddr == smp_addr(SMP_IDX_ASSIGN)) begin
                assign_q <= pwdata[7:0] & SMP_ASSIGN_MASK;
            end else if (paddr == smp_addr(SMP_IDX_DIR)) begin
                dir_q <= pwdata[7:0];
            end else if (paddr == smp_addr(SMP_IDX_CTRL)) begin
                ctrl_q <= pwdata[2:0];
            end
        end
    end
    // read mux, zero above the implemented bits
    always_comb begin
        rd_d = 32'h0;
        hit = 1'b1;
        if (paddr == smp_addr(SMP_IDX_DATA)) begin
            rd_d = {24'h0, pin_level};
        end else if (paddr == smp_addr(SMP_IDX_ASSIGN)) begin
            rd_d = {24'h0, assign_q};
        end else if (paddr == smp_addr(SMP_IDX_DIR)) begin
            rd_d = {24'h0, dir_q};
        end else if (paddr == smp_addr(SMP_IDX_CTRL)) begin
            rd_d = {23'h0, fault_flag, 5'h0, ctrl_q};
        end else begin
            hit = 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && st_q == SMP_IDLE) begin
            prdata <= pwrite ? 32'h0 : rd_d;
            pslverr <= ~hit;
        end else begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    assign_zero_a: assert property (@(posedge mclk) disable iff (reset)
        (assign_q[2] == 1'b0) && (assign_q[7] == 1'b0))
        else $error("unimplemented assign bits set");
    ready_pulse_a: assert property (@(posedge mclk) disable iff (reset)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("pready not a one cycle answer");
    data_write_a: assert property (@(posedge mclk) disable iff (reset)
        wr_go && paddr == smp_addr(SMP_IDX_DATA)
        |=> data_q == $past(pwdata[7:0]))
        else $error("data register missed a write");
endmodule // smp_apb

// ### design/smp_pinmux.sv
// combinational routing of serial and io functions onto the eight pins
// assumes serial master and transmitter drive their own request lines
`timescale 1ns/1ps
module smp_pinmux (
    // configuration
    input wire logic [7:0] data_q,
    input wire logic [7:0] assign_q,
    input wire logic [7:0] dir_q,
    input wire logic master_enable,
    input wire logic master_mode,
    input wire logic tx_enable,
    // serial functions
    input wire logic [7:0] func_out,
    input wire logic txd_out,
    // pin controls, enable low while driving
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n
);
    import smp_pkg::*;
    logic [7:0] owned;
    logic [7:0] fdrv;
    // which pins the serial master owns
    always_comb begin
        owned = master_enable ? assign_q : 8'h00;
        owned[SMP_PIN_SCK] = master_enable;
        owned[SMP_PIN_TXD] = 1'b0;
    end
    // function drive per pin, direction gates in both uses
    always_comb begin
        fdrv = dir_q;
        if (!master_mode) begin
            fdrv[6:4] = 3'b000;
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (owned[i]) begin
                pin_o[i] = func_out[i];
                pin_oe_n[i] = ~fdrv[i];
            end else begin
                pin_o[i] = data_q[i];
                pin_oe_n[i] = ~dir_q[i];
            end
        end
        if (tx_enable) begin
            pin_o[SMP_PIN_TXD] = txd_out;
            pin_oe_n[SMP_PIN_TXD] = 1'b0;
        end
    end
endmodule // smp_pinmux

// ### design/smp_top.sv
// serial module pin control top: registers, pin routing, mode fault
// assumes pins are synchronous to mclk; pads resolve pin_oe_n
`timescale 1ns/1ps
module smp_top (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smp_pkg::SMP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port pins
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n,
    // receive pin
    input wire logic rxd_i,
    // serial master side
    input wire logic [7:0] func_out,
    output logic [7:0] func_in,
    output logic func_in_valid_miso,
    output logic func_in_valid_mosi,
    output logic func_sck_in_en,
    output logic func_select_en,
    output logic mode_fault,
    // transmitter and receiver side
    input wire logic txd_out,
    output logic rxd_in
);
    import smp_pkg::*;
    logic [7:0] data_q;
    logic [7:0] assign_q;
    logic [7:0] dir_q;
    logic [2:0] ctrl_q;
    logic [7:0] mux_o;
    logic [7:0] mux_oe_n;
    logic fault_q;
    logic ena;
    logic mstr;
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    smp_apb u_apb (
        .mclk(mclk),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .data_q(data_q),
        .assign_q(assign_q),
        .dir_q(dir_q),
        .ctrl_q(ctrl_q),
        .pin_level(pin_i),
        .fault_flag(fault_q)
    );
    assign ena = ctrl_q[SMP_CTRL_ENA];
    assign mstr = ctrl_q[SMP_CTRL_MSTR];
    smp_pinmux u_mux (
        .data_q(data_q),
        .assign_q(assign_q),
        .dir_q(dir_q),
        .master_enable(ena),
        .master_mode(mstr),
        .tx_enable(ctrl_q[SMP_CTRL_TE]),
        .func_out(func_out),
        .txd_out(txd_out),
        .pin_o(mux_o),
        .pin_oe_n(mux_oe_n)
    );
    // ------------------------------------------------------------
    // registered pin drive and inputs to the serial units
    // ------------------------------------------------------------
    // registered so every output comes from a flop; one cycle of lag
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_o <= 8'h00;
            pin_oe_n <= 8'hff;
            func_in <= 8'h00;
            rxd_in <= 1'b1;
        end else begin
            pin_o <= mux_o;
            pin_oe_n <= mux_oe_n;
            func_in <= pin_i;
            rxd_in <= rxd_i;
        end
    end
    // input qualifiers for the serial master per direction bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            func_in_valid_miso <= 1'b0;
            func_in_valid_mosi <= 1'b0;
            func_sck_in_en <= 1'b0;
            func_select_en <= 1'b0;
        end else begin
            func_in_valid_miso <= ena && assign_q[SMP_PIN_MISO] && mstr
                && !dir_q[SMP_PIN_MISO];
            func_in_valid_mosi <= ena && assign_q[SMP_PIN_MOSI] && !mstr
                && !dir_q[SMP_PIN_MOSI];
            func_sck_in_en <= ena && !mstr && !dir_q[SMP_PIN_SCK];
            func_select_en <= ena && assign_q[SMP_PIN_CS0] && !mstr
                && !dir_q[SMP_PIN_CS0] && !pin_i[SMP_PIN_CS0];
        end
    end
    // mode fault: asserted (low) cs0 input while master
    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_q <= 1'b0;
            mode_fault <= 1'b0;
        end else begin
            fault_q <= ena && mstr && assign_q[SMP_PIN_CS0]
                && !dir_q[SMP_PIN_CS0] && !pin_i[SMP_PIN_CS0];
            mode_fault <= ena && mstr && assign_q[SMP_PIN_CS0]
                && !dir_q[SMP_PIN_CS0] && !pin_i[SMP_PIN_CS0];
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    tx_drive_a: assert property (@(posedge mclk) disable iff (reset)
        ctrl_q[SMP_CTRL_TE] |=> !pin_oe_n[SMP_PIN_TXD]
        && pin_o[SMP_PIN_TXD] == $past(txd_out))
        else $error("txd pin not driven by transmitter");
    gpio_drive_a: assert property (@(posedge mclk) disable iff (reset)
        !ena && !ctrl_q[SMP_CTRL_TE] |=> pin_o == $past(data_q)
        && pin_oe_n == ~$past(dir_q))
        else $error("io pins not following data and direction");
    sck_own_a: assert property (@(posedge mclk) disable iff (reset)
        ena |=> pin_o[SMP_PIN_SCK] == $past(func_out[SMP_PIN_SCK]))
        else $error("sck pin not routed to master");
    cs_slave_a: assert property (@(posedge mclk) disable iff (reset)
        ena && !mstr |=> pin_oe_n[6:4] == ~($past(dir_q[6:4])
        & ~$past(assign_q[6:4])))
        else $error("chip selects active in slave mode");
    assign_io_a: assert property (@(posedge mclk) disable iff (reset)
        ena && !assign_q[SMP_PIN_MISO] |=> pin_o[SMP_PIN_MISO]
        == $past(data_q[SMP_PIN_MISO]))
        else $error("unassigned pin taken by master");
    rxd_pass_a: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> rxd_in == $past(rxd_i))
        else $error("receive input not passed");
    fault_src_a: assert property (@(posedge mclk) disable iff (reset)
        mode_fault |-> $past(mstr && !dir_q[SMP_PIN_CS0]))
        else $error("mode fault without master input select");
    miso_in_a: assert property (@(posedge mclk) disable iff (reset)
        func_in_valid_miso |-> $past(!dir_q[SMP_PIN_MISO] && mstr))
        else $error("miso input enabled wrongly");
endmodule // smp_top

// ### dv/smp_pins_model.sv
// partner model: peripherals and pull-ups on the eight port pins
// assumes pin_oe_n low means the device drives the pin
`timescale 1ns/1ps
module smp_pins_model (
    // device side
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n,
    // peripheral side
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_i
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // device drive wins, then the peripheral; a pin nobody drives floats high on its pull-up
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (!pin_oe_n[b]) pin_i[b] = pin_o[b];
            else if (ext_en[b]) pin_i[b] = ext_val[b];
            else pin_i[b] = 1'b1;
        end
    end
endmodule // smp_pins_model

// ### dv/smp_top_tb.sv
// self-checking bench for the pin control top, with a reference model
// assumes the apb slave answers in its own time; one 20 mhz clock
`timescale 1ns/1ps
module smp_top_tb;
    import smp_pkg::*;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [SMP_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, rxd_i = 1, txd_out = 0, rxd_in;
    logic [7:0] pin_i, pin_o, pin_oe_n, func_out = 8'h00, func_in;
    logic [7:0] ext_val = 8'hff, ext_en = 8'h00;
    logic v_miso, v_mosi, sck_en, sel_en, mode_fault;
    int n_mismatch = 0, num_checks = 0, seed = 39;
    int m_data = 0, m_assign = 0, m_dir = 0, m_ctrl = 0;

    always #25 mclk = ~mclk;

    smp_top DUT (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .rxd_i(rxd_i), .func_out(func_out),
        .func_in(func_in), .func_in_valid_miso(v_miso),
        .func_in_valid_mosi(v_mosi), .func_sck_in_en(sck_en),
        .func_select_en(sel_en), .mode_fault(mode_fault),
        .txd_out(txd_out), .rxd_in(rxd_in));

    smp_pins_model PINS (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) n_mismatch++;
    endtask

    // pins follow a register change one cycle after the write lands
    task automatic check_pins();
        logic [7:0] oe, lv;
        logic en, ms, ser;
        repeat (2) @(posedge mclk);
        #1;
        en = m_ctrl[SMP_CTRL_ENA];
        ms = m_ctrl[SMP_CTRL_MSTR];
        for (int b = 0; b < 8; b++) begin
            ser = en && (b == 2 || (b != 7 && m_assign[b]));
            // direction rules in both uses; slave chip selects stay off
            if (b == 7 && m_ctrl[SMP_CTRL_TE]) oe[b] = 1'b0;
            else if (ser && b >= 4 && b <= 6 && !ms) oe[b] = 1'b1;
            else oe[b] = !m_dir[b];
            if (!oe[b]) lv[b] = (b == 7 && m_ctrl[SMP_CTRL_TE]) ? txd_out
                : ser ? func_out[b] : m_data[b];
            else lv[b] = ext_en[b] ? ext_val[b] : 1'b1;
        end
        chk(32'(pin_oe_n), 32'(oe));
        chk(32'(pin_o & ~oe), 32'(lv & ~oe));
        chk(32'(func_in), 32'(lv));
        chk(32'(rxd_in), 32'(rxd_i));
        chk(32'({v_miso, v_mosi}), 32'({en & ms & m_assign[0] & !m_dir[0],
            en & !ms & m_assign[1] & !m_dir[1]}));
        chk(32'({sck_en, sel_en}), 32'({en & !ms & !m_dir[2],
            en & !ms & m_assign[3] & !m_dir[3] & !lv[3]}));
        chk(32'(mode_fault), 32'(en & ms & m_assign[3] & !m_dir[3]
            & !lv[3]));
        apb(1'b0, SMP_IDX_DATA, 32'h0);
        chk(rd, 32'(lv));
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    // watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        // reset values, reserved bits, unmapped address
        apb(1'b0, SMP_IDX_ASSIGN, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, SMP_IDX_DIR, 32'h0);
        chk(rd, 32'h0);
        check_pins();
        apb(1'b1, SMP_IDX_ASSIGN, 32'hffffffff);
        apb(1'b0, SMP_IDX_ASSIGN, 32'h0);
        chk(rd, 32'h7b);
        apb(1'b1, 16'h0fff, 32'h55);
        chk(32'(err), 32'h1);
        apb(1'b0, 16'h0fff, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, SMP_IDX_ASSIGN, 32'h0);
        $display("test registers done");
        // general io: data first, then direction
        for (int i = 0; i < 12; i++) begin
            ext_val <= 8'($random(seed));
            ext_en <= 8'($random(seed));
            rxd_i <= 1'($random(seed));
            m_data = $random(seed) & 8'hff;
            m_dir = $random(seed) & 8'hff;
            apb(1'b1, SMP_IDX_DATA, 32'(m_data));
            apb(1'b1, SMP_IDX_DIR, 32'(m_dir));
            check_pins();
        end
        $display("test general io done");
        // serial routing over every enable, mode and transmit setting
        m_assign = 32'h7b;
        apb(1'b1, SMP_IDX_ASSIGN, 32'hff);
        for (int i = 0; i < 16; i++) begin
            ext_val <= 8'($random(seed));
            ext_en <= 8'($random(seed));
            func_out <= 8'($random(seed));
            txd_out <= 1'($random(seed));
            m_ctrl = i % 8;
            m_dir = $random(seed) & 8'hff;
            apb(1'b1, SMP_IDX_DIR, 32'(m_dir));
            apb(1'b1, SMP_IDX_CTRL, 32'(m_ctrl));
            check_pins();
        end
        // chip-select 0 pulled low while master: fault raised
        ext_en <= 8'hff;
        ext_val <= 8'h00;
        m_dir = 0;
        m_ctrl = 3;
        apb(1'b1, SMP_IDX_DIR, 32'h0);
        apb(1'b1, SMP_IDX_CTRL, 32'h3);
        check_pins();
        apb(1'b0, SMP_IDX_CTRL, 32'h0);
        chk(rd, 32'h103);
        $display("test serial routing done");
        // mid-run reset returns every register and pin to idle
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        m_data = 0;
        m_assign = 0;
        m_dir = 0;
        m_ctrl = 0;
        apb(1'b0, SMP_IDX_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, SMP_IDX_ASSIGN, 32'h0);
        chk(rd, 32'h0);
        check_pins();
        $display("test mid-run reset done");
        close_out();
    end
endmodule // smp_top_tb
